// ### rtl/ypof_top.sv
// ycbcr 4:2:2 parallel output formatter with apb control
// assumes pairs arrive on pclk; link_clk is an asynchronous pin sampled here
//
// What this block does
// - msb alignment: 8-bit words on dout[15:8], 10-bit words on dout[15:6].
// - lsb alignment: 8-bit words on dout[7:0], 10-bit words on dout[9:0].
// - two-clock order Cb, Y0, Cr, Y1; chroma even words, luma odd.
// - 16-bit mode: Cb with Y0, then Cr with Y1, alignment ignored.
// - 8-bit codes: luma held to 16..235, chroma to 16..240.
// - 10-bit codes: luma held to 64..940, chroma to 64..960.
// - any of the three ycc 4:2:2 modes is selectable for progressive output.
// - data goes out with pixel clock, frame valid and line valid.
// - chroma swap exchanges Cb and Cr; luma swap puts Y first; both combine.
// - each component is 8 or 10 bits; a pixel takes two pixel clocks, or one in 16-bit mode.
//
// Implementation choices: the address map and the APB interface to the registers.
`default_nettype none

module ypof_top
    import ypof_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output wire logic [31:0] prdata,
    output wire logic        pready,
    output wire logic        pslverr,
    input  wire logic        in_valid,
    input  wire ypof_pair_t  in_pair,
    output wire logic        in_ready,
    input  wire logic        link_clk,
    output wire logic        pix_clk,
    output wire logic        frame_valid,
    output wire logic        line_valid,
    output wire logic [15:0] dout
);

    ypof_ctrl_t             ctrl_q;
    ypof_ctrl_t             cfg_q;
    ypof_ctrl_t             ocfg_q;
    ypof_pair_t             cur_q;
    ypof_state_t            state_q;
    logic [1:0]             idx_q;
    logic [15:0]            dout_q;
    logic                   lv_q;
    logic                   fv_q;
    logic                   luma_q;
    logic [31:0]            prdata_q;
    logic                   pready_q;
    logic                   pslverr_q;
    logic                   lclk_s1_q;
    logic                   lclk_s2_q;
    logic                   lclk_s3_q;
    logic                   lclk_fall;
    logic                   fifo_valid;
    logic                   fifo_ready;
    ypof_pair_t             fifo_pair;
    logic [YPOF_CNT_W-1:0]  fifo_cnt;
    logic                   luma_sel;
    logic [9:0]             comp;
    logic [9:0]             c_first;
    logic [9:0]             c_second;
    logic [7:0]             cl8;
    logic [9:0]             cl10;
    logic [7:0]             y8;
    logic [7:0]             ch8;
    logic [15:0]            word_d;
    logic [1:0]             last_idx;
    logic                   setup;
    logic                   wr_en;

    function automatic logic [9:0] clamp10(logic [9:0] v, logic [9:0] lo, logic [9:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [7:0] clamp8(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // depth 8 absorbs upstream jitter; ready falls when full and stalls the source
    ypof_fifo #(
        .WIDTH (YPOF_PAIR_W),
        .DEPTH (YPOF_FIFO_DEPTH),
        .CW    (YPOF_CNT_W)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (in_valid),
        .in_data   (in_pair),
        .in_ready  (in_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_pair),
        .out_ready (fifo_ready),
        .count     (fifo_cnt)
    );

    assign fifo_ready = (state_q == YPOF_ST_IDLE) && ctrl_q.enable;

    // link clock synchroniser; s2 and s3 feed the edge detector
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lclk_s1_q <= 1'b0;
            lclk_s2_q <= 1'b0;
            lclk_s3_q <= 1'b0;
        end else begin
            lclk_s1_q <= link_clk;
            lclk_s2_q <= lclk_s1_q;
            lclk_s3_q <= lclk_s2_q;
        end
    end

    assign lclk_fall = lclk_s3_q && !lclk_s2_q;

    // apb slave: zero wait states, data prepared in setup
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pwrite && pready_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && (paddr != YPOF_CTRL_OFS) && (paddr != YPOF_STAT_OFS);
            if (setup) begin
                prdata_q <= 32'h0000_0000;
                if (!pwrite && paddr == YPOF_CTRL_OFS) begin
                    prdata_q[YPOF_CTRL_SWY_BIT:0] <= ctrl_q;
                end else if (!pwrite && paddr == YPOF_STAT_OFS) begin
                    prdata_q[YPOF_STAT_FV_BIT]   <= fv_q;
                    prdata_q[YPOF_STAT_LV_BIT]   <= lv_q;
                    prdata_q[YPOF_STAT_BUSY_BIT] <= (state_q != YPOF_ST_IDLE);
                    prdata_q[YPOF_STAT_CNT_LSB +: YPOF_CNT_W] <= fifo_cnt;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= YPOF_CTRL_RST;
        end else if (wr_en && paddr == YPOF_CTRL_OFS) begin
            ctrl_q.enable    <= pwdata[YPOF_CTRL_EN_BIT];
            ctrl_q.msb_align <= pwdata[YPOF_CTRL_ALN_BIT];
            ctrl_q.swap_crcb <= pwdata[YPOF_CTRL_SWC_BIT];
            ctrl_q.swap_yc   <= pwdata[YPOF_CTRL_SWY_BIT];
            // the reserved mode code falls back to 8-bit
            ctrl_q.mode <= (pwdata[YPOF_CTRL_MODE_LSB +: 2] == 2'h3) ? YPOF_MODE_8
                         : ypof_mode_t'(pwdata[YPOF_CTRL_MODE_LSB +: 2]);
        end
    end

    assign c_first  = cfg_q.swap_crcb ? cur_q.cr : cur_q.cb;
    assign c_second = cfg_q.swap_crcb ? cur_q.cb : cur_q.cr;
    assign last_idx = (cfg_q.mode == YPOF_MODE_16) ? 2'h1 : 2'h3;

    always_comb begin
        luma_sel = 1'b0;
        comp     = 10'h000;
        cl8      = 8'h00;
        cl10     = 10'h000;
        y8       = 8'h00;
        ch8      = 8'h00;
        word_d   = 16'h0000;
        luma_sel = idx_q[0] ^ cfg_q.swap_yc;
        if (luma_sel) begin
            comp = idx_q[1] ? cur_q.y1 : cur_q.y0;
        end else begin
            comp = idx_q[1] ? c_second : c_first;
        end
        cl8 = luma_sel ? clamp8(comp[9:2], YPOF_Y8_MIN, YPOF_Y8_MAX)
                       : clamp8(comp[9:2], YPOF_C8_MIN, YPOF_C8_MAX);
        y8  = clamp8(idx_q[0] ? cur_q.y1[9:2] : cur_q.y0[9:2], YPOF_Y8_MIN, YPOF_Y8_MAX);
        ch8 = clamp8(idx_q[0] ? c_second[9:2] : c_first[9:2], YPOF_C8_MIN, YPOF_C8_MAX);
        cl10 = luma_sel ? clamp10(comp, YPOF_Y10_MIN, YPOF_Y10_MAX)
                        : clamp10(comp, YPOF_C10_MIN, YPOF_C10_MAX);
        unique case (cfg_q.mode)
            YPOF_MODE_8: begin
                word_d = cfg_q.msb_align ? {cl8, 8'h00} : {8'h00, cl8};
            end
            YPOF_MODE_10: begin
                word_d = cfg_q.msb_align ? {cl10, 6'h00} : {6'h00, cl10};
            end
            YPOF_MODE_16: begin
                word_d = cfg_q.swap_yc ? {y8, ch8} : {ch8, y8};
            end
            default: begin
                word_d = 16'h0000;
            end
        endcase
    end

    // one pair is two or four words, one per pixel clock
    // config is latched per pair so a register write never splits a pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= YPOF_ST_IDLE;
            cfg_q   <= YPOF_CTRL_RST;
            cur_q   <= '0;
            idx_q   <= 2'h0;
        end else begin
            unique case (state_q)
                YPOF_ST_IDLE: begin
                    if (fifo_valid && ctrl_q.enable) begin
                        cur_q   <= fifo_pair;
                        cfg_q   <= ctrl_q;
                        idx_q   <= 2'h0;
                        state_q <= YPOF_ST_SEND;
                    end
                end
                YPOF_ST_SEND: begin
                    if (lclk_fall) begin
                        idx_q <= idx_q + 2'h1;
                        if (idx_q == last_idx) begin
                            state_q <= cur_q.eof ? YPOF_ST_FEND
                                     : (cur_q.eol ? YPOF_ST_GAP : YPOF_ST_IDLE);
                        end
                    end
                end
                YPOF_ST_GAP, YPOF_ST_FEND: begin
                    if (lclk_fall) begin
                        state_q <= YPOF_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pins change on the falling pixel clock so the receiver samples on the rise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dout_q <= 16'h0000;
            lv_q   <= 1'b0;
            fv_q   <= 1'b0;
            luma_q <= 1'b0;
            ocfg_q <= YPOF_CTRL_RST;
        end else if (lclk_fall) begin
            if (state_q == YPOF_ST_SEND) begin
                dout_q <= word_d;
                lv_q   <= 1'b1;
                fv_q   <= 1'b1;
                luma_q <= luma_sel;
                // cfg_q moves on when the next pair loads while the last word still stands,
                // so the lane checks need the config that went out with this word
                ocfg_q <= cfg_q;
            end else begin
                dout_q <= 16'h0000;
                lv_q   <= 1'b0;
                luma_q <= 1'b0;
                if (state_q == YPOF_ST_FEND) begin
                    fv_q <= 1'b0;
                end
            end
        end
    end

    assign prdata      = prdata_q;
    assign pready      = pready_q;
    assign pslverr     = pslverr_q;
    assign pix_clk     = lclk_s3_q;
    assign frame_valid = fv_q;
    assign line_valid  = lv_q;
    assign dout        = dout_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    line_in_frame_a: assert property (lv_q |-> fv_q)
        else $error("line valid without frame valid");
    data_on_fall_a: assert property ($changed(dout_q) |-> $fell(lclk_s3_q))
        else $error("data changed away from pixel clock fall");
    msb8_lanes_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_8 && ocfg_q.msb_align |-> dout_q[7:0] == 8'h00)
        else $error("msb 8-bit word leaked into low lines");
    msb10_lanes_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_10 && ocfg_q.msb_align |-> dout_q[5:0] == 6'h00)
        else $error("msb 10-bit word leaked into low lines");
    lsb_lanes_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_10 && !ocfg_q.msb_align |-> dout_q[15:10] == 6'h00)
        else $error("lsb 10-bit word leaked into high lines");
    lsb8_lanes_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_8 && !ocfg_q.msb_align |-> dout_q[15:8] == 8'h00)
        else $error("lsb 8-bit word leaked into high lines");
    luma8_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_8 && !ocfg_q.msb_align && luma_q
        |-> dout_q[7:0] >= YPOF_Y8_MIN && dout_q[7:0] <= YPOF_Y8_MAX)
        else $error("8-bit luma out of range");
    chroma8_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_8 && !ocfg_q.msb_align && !luma_q
        |-> dout_q[7:0] >= YPOF_C8_MIN && dout_q[7:0] <= YPOF_C8_MAX)
        else $error("8-bit chroma out of range");
    chroma16_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_16 && !ocfg_q.swap_yc
        |-> dout_q[15:8] >= YPOF_C8_MIN && dout_q[15:8] <= YPOF_C8_MAX
            && dout_q[7:0] >= YPOF_Y8_MIN && dout_q[7:0] <= YPOF_Y8_MAX)
        else $error("16-bit word out of range");
    swap16_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_16 && ocfg_q.swap_yc
        |-> dout_q[15:8] >= YPOF_Y8_MIN && dout_q[15:8] <= YPOF_Y8_MAX
            && dout_q[7:0] >= YPOF_C8_MIN && dout_q[7:0] <= YPOF_C8_MAX)
        else $error("swapped 16-bit word out of range");
    luma10_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_10 && !ocfg_q.msb_align && luma_q
        |-> dout_q[9:0] >= YPOF_Y10_MIN && dout_q[9:0] <= YPOF_Y10_MAX)
        else $error("10-bit luma out of range");
    chroma10_range_a: assert property (
        lv_q && ocfg_q.mode == YPOF_MODE_10 && !ocfg_q.msb_align && !luma_q
        |-> dout_q[9:0] >= YPOF_C10_MIN && dout_q[9:0] <= YPOF_C10_MAX)
        else $error("10-bit chroma out of range");
    chroma_first_a: assert property (
        $rose(lv_q) && ocfg_q.mode != YPOF_MODE_16 && !ocfg_q.swap_yc |-> !luma_q)
        else $error("line did not open with chroma");
    luma_first_a: assert property (
        $rose(lv_q) && ocfg_q.mode != YPOF_MODE_16 && ocfg_q.swap_yc |-> luma_q)
        else $error("swapped line did not open with luma");
    line_pace_a: assert property ($rose(lv_q) |-> $fell(lclk_s3_q))
        else $error("line valid rose away from pixel clock fall");
    frame_open_a: assert property ($rose(fv_q) |-> lv_q)
        else $error("frame valid rose without a word");
    frame_close_a: assert property (
        state_q == YPOF_ST_FEND && lclk_fall |=> !fv_q && !lv_q)
        else $error("frame valid did not close after the last pair");
    idle_low_a: assert property (!lv_q |-> dout_q == 16'h0000)
        else $error("data lines not low outside a line");
    apb_pulse_a: assert property (setup |=> pready_q ##1 !pready_q)
        else $error("apb ready not a single pulse");
    apb_error_a: assert property (pslverr_q |-> pready_q)
        else $error("apb error without ready");

endmodule

`default_nettype wire

// ### rtl/ypof_pkg.sv
// shared types and constants of the ycbcr parallel output formatter
// assumes one 40 mhz apb clock domain; the link clock arrives as a plain pin
`default_nettype none

package ypof_pkg;

    // register byte offsets
    localparam logic [11:0] YPOF_CTRL_OFS      = 12'h000;
    localparam logic [11:0] YPOF_STAT_OFS      = 12'h004;

    // control field positions
    localparam int          YPOF_CTRL_EN_BIT   = 0;
    localparam int          YPOF_CTRL_MODE_LSB = 1;
    localparam int          YPOF_CTRL_ALN_BIT  = 3;
    localparam int          YPOF_CTRL_SWC_BIT  = 4;
    localparam int          YPOF_CTRL_SWY_BIT  = 5;

    // status field positions
    localparam int          YPOF_STAT_FV_BIT   = 0;
    localparam int          YPOF_STAT_LV_BIT   = 1;
    localparam int          YPOF_STAT_BUSY_BIT = 2;
    localparam int          YPOF_STAT_CNT_LSB  = 4;

    // component code ranges
    localparam logic [7:0]  YPOF_Y8_MIN        = 8'h10;
    localparam logic [7:0]  YPOF_Y8_MAX        = 8'heb;
    localparam logic [7:0]  YPOF_C8_MIN        = 8'h10;
    localparam logic [7:0]  YPOF_C8_MAX        = 8'hf0;
    localparam logic [9:0]  YPOF_Y10_MIN       = 10'h040;
    localparam logic [9:0]  YPOF_Y10_MAX       = 10'h3ac;
    localparam logic [9:0]  YPOF_C10_MIN       = 10'h040;
    localparam logic [9:0]  YPOF_C10_MAX       = 10'h3c0;

    localparam int          YPOF_FIFO_DEPTH    = 8;
    localparam int          YPOF_CNT_W         = 4;

    typedef enum logic [1:0] {
        YPOF_MODE_8  = 2'h0,
        YPOF_MODE_10 = 2'h1,
        YPOF_MODE_16 = 2'h2
    } ypof_mode_t;

    typedef struct packed {
        logic       swap_yc;
        logic       swap_crcb;
        logic       msb_align;
        ypof_mode_t mode;
        logic       enable;
    } ypof_ctrl_t;

    localparam ypof_ctrl_t YPOF_CTRL_RST = '{1'b0, 1'b0, 1'b0, YPOF_MODE_8, 1'b0};

    // one pixel pair from upstream, components in 10-bit codes
    typedef struct packed {
        logic       eof;
        logic       eol;
        logic [9:0] cb;
        logic [9:0] y0;
        logic [9:0] cr;
        logic [9:0] y1;
    } ypof_pair_t;

    localparam int YPOF_PAIR_W = $bits(ypof_pair_t);

    typedef enum logic [3:0] {
        YPOF_ST_IDLE = 4'h1,
        YPOF_ST_SEND = 4'h2,
        YPOF_ST_GAP  = 4'h4,
        YPOF_ST_FEND = 4'h8
    } ypof_state_t;

endpackage

`default_nettype wire

// ### rtl/ypof_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes both sides run on the same clock
`default_nettype none

module ypof_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8,
    parameter int CW    = $clog2(DEPTH + 1)
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output wire logic             in_ready,
    output wire logic             out_valid,
    output wire logic [WIDTH-1:0] out_data,
    input  wire logic             out_ready,
    output wire logic [CW-1:0]    count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             full_q;
    logic             push;
    logic             pop;

    assign push      = in_valid && !full_q;
    assign pop       = out_ready && (cnt_q != '0);
    assign in_ready  = !full_q;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem[rd_q];
    assign count     = cnt_q;

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q   <= '0;
            rd_q   <= '0;
            cnt_q  <= '0;
            full_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
            end
            cnt_q  <= cnt_d;
            full_q <= (cnt_d == CW'(DEPTH));
        end
    end

endmodule

`default_nettype wire

// ### sim/ypof_rx_model.sv
// receiver model on the far side of the pixel bus
// assumes pix_clk is a pclk-domain flop output, so pclk may sample it
`default_nettype none

module ypof_rx_model (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pix_clk,
    input wire logic        frame_valid,
    input wire logic        line_valid,
    input wire logic [15:0] dout
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] words[$];
    logic        pix_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pix_q <= 1'b0;
        end else begin
            pix_q <= pix_clk;
            if (pix_clk && !pix_q && frame_valid && line_valid) begin
                words.push_back(dout);
            end
        end
    end
endmodule

`default_nettype wire

// ### sim/ypof_top_tb.sv
// self-checking bench of the pixel output formatter
// assumes the receiver model beside it and apb answers as the note says
`default_nettype none

module ypof_top_tb;
    import ypof_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        in_valid;
    ypof_pair_t  in_pair;
    logic        in_ready;
    logic        link_clk;
    logic        pix_clk;
    logic        frame_valid;
    logic        line_valid;
    logic [15:0] dout;
    int          err_total;
    int          comparisons;

    ypof_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_pair(in_pair),
        .in_ready(in_ready), .link_clk(link_clk), .pix_clk(pix_clk),
        .frame_valid(frame_valid), .line_valid(line_valid), .dout(dout));

    ypof_rx_model rx (.pclk(pclk), .presetn(presetn), .pix_clk(pix_clk),
        .frame_valid(frame_valid), .line_valid(line_valid), .dout(dout));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // link clock free-running, phase unrelated to pclk
    initial begin
        link_clk = 1'b0;
        #37;
        forever #100 link_clk = ~link_clk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (!pready && n < 100) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 100) begin
            err_total++;
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic send(input ypof_pair_t p);
        int n;
        n = 0;
        @(posedge pclk);
        in_valid <= 1'b1;
        in_pair  <= p;
        @(posedge pclk);
        while (!in_ready && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) begin
            err_total++;
        end
        in_valid <= 1'b0;
    endtask

    function automatic logic [7:0] c8(input logic [9:0] v, input logic y);
        logic [7:0] b;
        logic [7:0] hi;
        b  = v[9:2];
        hi = y ? YPOF_Y8_MAX : YPOF_C8_MAX;
        return (b < YPOF_C8_MIN) ? YPOF_C8_MIN : ((b > hi) ? hi : b);
    endfunction

    function automatic logic [9:0] c10(input logic [9:0] v, input logic y);
        logic [9:0] hi;
        hi = y ? YPOF_Y10_MAX : YPOF_C10_MAX;
        return (v < YPOF_C10_MIN) ? YPOF_C10_MIN : ((v > hi) ? hi : v);
    endfunction

    // expected word k of a pair under control value c
    function automatic logic [15:0] exp_word(input logic [5:0] c, input ypof_pair_t p,
                                             input int k);
        logic [9:0] c1;
        logic [9:0] c2;
        logic [9:0] v;
        logic       is_y;
        c1 = c[4] ? p.cr : p.cb;
        c2 = c[4] ? p.cb : p.cr;
        if (c[2:1] == 2'h2) begin
            return c[5] ? {c8(k ? p.y1 : p.y0, 1'b1), c8(k ? c2 : c1, 1'b0)}
                        : {c8(k ? c2 : c1, 1'b0), c8(k ? p.y1 : p.y0, 1'b1)};
        end
        is_y = k[0] ^ c[5];
        v = is_y ? ((k >= 2) ? p.y1 : p.y0) : ((k >= 2) ? c2 : c1);
        if (c[2:1] == 2'h1) begin
            return c[3] ? {c10(v, is_y), 6'h00} : {6'h00, c10(v, is_y)};
        end
        return c[3] ? {c8(v, is_y), 8'h00} : {8'h00, c8(v, is_y)};
    endfunction

    task automatic wait_words(input int total);
        int n;
        n = 0;
        while (rx.words.size() < total && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
        end
        repeat (30) @(posedge pclk);
    endtask

    task automatic test_regs();
        logic [31:0] r;
        logic        e;
        apb(1'b0, YPOF_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b1, YPOF_CTRL_OFS, 32'h0000003e, r, e);
        apb(1'b0, YPOF_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h00000038); // reserved mode code reads back as 8-bit
        apb(1'b1, YPOF_CTRL_OFS, 32'h00000006, r, e);
        apb(1'b0, YPOF_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b1, YPOF_STAT_OFS, 32'h000000ff, r, e);
        chk({31'h0, e}, 32'h0);
        apb(1'b0, YPOF_STAT_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, 12'h008, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_modes();
        logic [5:0]  cfg [10] = '{6'h01, 6'h09, 6'h03, 6'h0b, 6'h05, 6'h0d,
                                  6'h11, 6'h21, 6'h31, 6'h25};
        logic [31:0] r;
        logic        e;
        ypof_pair_t  p;
        int          base;
        int          cnt;
        p = '{1'b1, 1'b1, 10'h000, 10'h3ff, 10'h2a5, 10'h155};
        for (int i = 0; i < 10; i++) begin
            apb(1'b1, YPOF_CTRL_OFS, {26'h0, cfg[i]}, r, e);
            base = rx.words.size();
            cnt  = (cfg[i][2:1] == 2'h2) ? 2 : 4;
            send(p);
            wait_words(base + cnt);
            chk(rx.words.size() - base, cnt);
            for (int k = 0; k < cnt; k++) begin
                chk(rx.words[base + k], exp_word(cfg[i], p, k));
            end
            chk({31'h0, frame_valid}, 32'h0);
        end
        $display("test_modes done");
    endtask

    task automatic test_fill();
        logic [31:0] r;
        logic        e;
        ypof_pair_t  p [8];
        int          base;
        apb(1'b1, YPOF_CTRL_OFS, 32'h00000003, r, e);
        apb(1'b1, YPOF_CTRL_OFS, 32'h00000002, r, e);
        for (int i = 0; i < 8; i++) begin
            p[i] = '{i == 7, 1'b1, 10'h100 + 10'(i), 10'h200 + 10'(i), 10'h0c0, 10'h3c0};
            send(p[i]);
        end
        repeat (3) @(posedge pclk);
        chk({31'h0, in_ready}, 32'h0);
        apb(1'b0, YPOF_STAT_OFS, 32'h0, r, e);
        chk(r[7:4], 32'h8);
        base = rx.words.size();
        apb(1'b1, YPOF_CTRL_OFS, 32'h00000003, r, e);
        wait_words(base + 32);
        chk(rx.words.size() - base, 32);
        for (int k = 0; k < 32; k++) begin
            chk(rx.words[base + k], exp_word(6'h03, p[k / 4], k % 4));
        end
        chk({31'h0, in_ready}, 32'h1);
        $display("test_fill done");
    endtask

    // limit far above the thousand or so cycles the tests need
    initial begin
        #500000;
        err_total++;
        give_verdict();
    end

    initial begin
        err_total   = 0;
        comparisons = 0;
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        in_valid    = 1'b0;
        in_pair     = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_modes();
        test_fill();
        give_verdict();
    end
endmodule

`default_nettype wire
